// ===== logic/timer_channel_capture_compare_pwm.sv
// How it works
// (RULE1) Center select off: each channel's two mode bits pick capture, compare or edge PWM.
// (RULE2) Capture latches the counter on the selected pin edge, except in a cycle with a channel control write.
// (RULE3) Reading one captured byte freezes both; channel control write resets it.
// (RULE4) Each capture sets the channel event flag.
// (RULE5) Compare match sets, clears or toggles the pin and sets the flag.
// (RULE6) Compare value takes effect after both bytes; control write resets pairing.
// (RULE7) Edge PWM: modulo period, value duty, level select A polarity.
// (RULE8) Edge PWM, A=0: overflow high, match low; A=1 the reverse.
// (RULE9) Edge PWM value zero gives 0 percent; above modulo gives 100 percent.
// (RULE10) Edge PWM value reloads after both bytes when the counter is zero.
// (RULE11) Center PWM counts up to modulo then down; period twice modulo.
// (RULE12) Software keeps center modulo within 0001 to 7FFF.
// (RULE13) Center PWM value zero or negative gives 0 percent; above modulo 100.
// (RULE14) Software never uses modulo zero in center mode.
// (RULE15) Center PWM, A=0: match counting up drives low, down drives high.
// (RULE16) Center mode buffers modulo and PWM values until the turnaround.
// (RULE17) Timer control write drops modulo bytes; channel control write drops value bytes.
// (RULE18) Compare and PWM modes set the flag on every counter match.
// (RULE19) Enabled flags hold a level interrupt request.
// (RULE20) Service software clears the flag before returning.
// (RULE21) Flags clear by read-while-set then write zero; new events win.
// (RULE22) Center mode overflow flag sets leaving the modulo value downward.
// (RULE23) Center PWM, A=1: match up drives high, match down drives low.
`timescale 1ns/1ps
`default_nettype none
module timer_channel_capture_compare_pwm #(
	parameter int NCH = 2
) (
	input wire logic pclk, // Bus clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [NCH-1:0] ch_in, // Channel pins, input side
	output logic [NCH-1:0] ch_out, // Channel pins, output level
	output logic [NCH-1:0] ch_oe, // Channel pins, output enable
	output logic overflow_irq, // Overflow interrupt request level
	output logic [NCH-1:0] channel_irq // Channel interrupt request levels
);
	import tmr_pkg::*;

	logic [7:0] tsc_reg;
	logic [15:0] cnt_reg, mod_reg, mod_buf_reg, cnt_lat_reg;
	logic [1:0] mod_wr_reg;
	logic cnt_lat_v_reg, down_reg, tof_arm_reg;
	logic [7:0] csc_reg [NCH];
	logic [15:0] cv_reg [NCH];
	logic [15:0] cv_buf_reg [NCH];
	logic [15:0] cv_lat_reg [NCH];
	logic [1:0] cv_wr_reg [NCH];
	logic [NCH-1:0] cv_lat_v_reg, ch_arm_reg, in_d_reg;
	logic [31:0] rdata_next;
	logic hit, wr_acc, rd_acc, run, cpwm, turn, ovf, cnt_wr;
	logic [REG_AW-1:0] idx;

	function automatic logic is_ch(input logic [REG_AW-1:0] i, input int c, input int k);
		return i == REG_AW'(CH_BASE_IDX + CH_STRIDE * c + k);
	endfunction

	function automatic logic in_map(input logic [REG_AW-1:0] i);
		return i < REG_AW'(CH_BASE_IDX + CH_STRIDE * NCH);
	endfunction

	assign idx = paddr[REG_AW+1:2];
	assign hit = psel & penable & pready;
	assign wr_acc = hit & pwrite & in_map(idx) & ~|paddr[31:REG_AW+2];
	assign rd_acc = hit & ~pwrite & in_map(idx) & ~|paddr[31:REG_AW+2];
	assign run = tsc_reg[BIT_RUN];
	assign cpwm = tsc_reg[BIT_CPWM];
	assign cnt_wr = wr_acc & (idx == CNTH_IDX || idx == CNTL_IDX);
	// Turnaround at the terminal count while counting up in center mode.
	assign turn = run & cpwm & ~down_reg & (cnt_reg == mod_reg); // [RULE11]
	assign ovf = cpwm ? turn : run & (cnt_reg == ((mod_reg == CNT_ZERO) ? CNT_ALL1 : mod_reg)); // [RULE22]

	// APB slave: one wait-free access phase, data prepared in the setup cycle.
	always_comb begin
		rdata_next = '0;
		case (idx)
			TSC_IDX: rdata_next[7:0] = tsc_reg;
			CNTH_IDX: rdata_next[7:0] = cnt_lat_v_reg ? cnt_lat_reg[15:8] : cnt_reg[15:8];
			CNTL_IDX: rdata_next[7:0] = cnt_lat_v_reg ? cnt_lat_reg[7:0] : cnt_reg[7:0];
			MODH_IDX: rdata_next[7:0] = mod_reg[15:8];
			MODL_IDX: rdata_next[7:0] = mod_reg[7:0];
			default: begin
				for (int c = 0; c < NCH; c++) begin
					if (is_ch(idx, c, 0))
						rdata_next[7:0] = csc_reg[c];
					if (is_ch(idx, c, 1))
						rdata_next[7:0] = cv_lat_v_reg[c] ? cv_lat_reg[c][15:8] : cv_reg[c][15:8];
					if (is_ch(idx, c, 2))
						rdata_next[7:0] = cv_lat_v_reg[c] ? cv_lat_reg[c][7:0] : cv_reg[c][7:0];
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			// The error stands only beside pready, and a refused read returns zero.
			pslverr <= psel & ~penable & (~in_map(idx) | (|paddr[31:REG_AW+2]));
			if (psel & ~penable)
				prdata <= (pwrite | ~in_map(idx) | (|paddr[31:REG_AW+2])) ? '0 : rdata_next;
		end
	end

	// Timer control, overflow flag and its two-step clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tsc_reg <= '0;
			tof_arm_reg <= 1'b0;
		end else begin
			if (wr_acc && idx == TSC_IDX)
				tsc_reg[6:0] <= (pwdata[6:0] & TSC_WMASK[6:0]);
			if (ovf) begin
				tsc_reg[BIT_FLAG] <= 1'b1; // [RULE21]
				tof_arm_reg <= 1'b0;
			end else if (wr_acc && idx == TSC_IDX && !pwdata[BIT_FLAG] && tof_arm_reg) begin
				tsc_reg[BIT_FLAG] <= 1'b0; // [RULE21]
				tof_arm_reg <= 1'b0;
			end else if (rd_acc && idx == TSC_IDX && tsc_reg[BIT_FLAG])
				tof_arm_reg <= 1'b1;
		end
	end

	// Counter: up with modulo wrap, or up/down in center mode.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
			down_reg <= 1'b0;
		end else if (cnt_wr) begin
			cnt_reg <= '0;
			down_reg <= 1'b0;
		end else if (run) begin
			if (!cpwm) begin
				down_reg <= 1'b0;
				cnt_reg <= ovf ? CNT_ZERO : cnt_reg + 16'h0001;
			end else if (turn) begin
				down_reg <= 1'b1; // [RULE11]
				cnt_reg <= cnt_reg - 16'h0001;
			end else if (down_reg && cnt_reg == CNT_ZERO) begin
				down_reg <= 1'b0; // [RULE11]
				cnt_reg <= cnt_reg + 16'h0001;
			end else
				cnt_reg <= down_reg ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
		end
	end

	// Counter read coherency: first byte read freezes both until either byte is read again.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_lat_reg <= '0;
			cnt_lat_v_reg <= 1'b0;
		end else begin
			if (cnt_wr)
				cnt_lat_v_reg <= 1'b0;
			else if (rd_acc && (idx == CNTH_IDX || idx == CNTL_IDX))
				cnt_lat_v_reg <= ~cnt_lat_v_reg;
			// Snapshot at the setup edge, where prdata samples too, so both bytes agree.
			if (psel && !penable && !pwrite && !cnt_lat_v_reg)
				cnt_lat_reg <= cnt_reg;
		end
	end

	// Modulo byte pair: applied at once in up mode, at the turnaround in center mode.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mod_reg <= '0;
			mod_buf_reg <= '0;
			mod_wr_reg <= '0;
		end else if (wr_acc && idx == TSC_IDX)
			mod_wr_reg <= '0; // [RULE17]
		else begin
			if (wr_acc && idx == MODH_IDX) begin
				mod_buf_reg[15:8] <= pwdata[7:0];
				mod_wr_reg[1] <= 1'b1;
			end
			if (wr_acc && idx == MODL_IDX) begin
				mod_buf_reg[7:0] <= pwdata[7:0];
				mod_wr_reg[0] <= 1'b1;
			end
			if (&mod_wr_reg && (!cpwm || turn)) begin
				mod_reg <= mod_buf_reg; // [RULE16]
				mod_wr_reg <= '0;
			end
		end
	end

	generate
		for (genvar c = 0; c < NCH; c++) begin : g_ch
			ch_mode_t mode;
			logic match, act, edge_hit, csc_wr, cap, evt, reload, out_next, pwm_on;
			logic [1:0] els;

			assign mode = ch_mode_t'({csc_reg[c][BIT_MSB], csc_reg[c][BIT_MSA]}); // [RULE1]
			assign els = {csc_reg[c][BIT_ELSB], csc_reg[c][BIT_ELSA]};
			assign act = csc_reg[c][BIT_ELSA];
			assign match = run & (cnt_reg == cv_reg[c]);
			assign csc_wr = wr_acc & is_ch(idx, c, 0);
			assign edge_hit = (els[0] & ch_in[c] & ~in_d_reg[c])
				| (els[1] & ~ch_in[c] & in_d_reg[c]); // [RULE2]
			assign cap = !cpwm && mode == M_CAPTURE && edge_hit;
			assign evt = cap | ((cpwm || mode != M_CAPTURE) && match); // [RULE4] [RULE18]
			assign pwm_on = cpwm | mode == M_EPWM | mode == M_EPWM2;
			// Compare reloads as soon as the pair is complete; PWM waits for the period edge.
			assign reload = &cv_wr_reg[c] & (cpwm ? turn : (!pwm_on || (run && cnt_reg == CNT_ZERO))); // [RULE6] [RULE10] [RULE16]

			always_comb begin
				out_next = ch_out[c];
				if (cpwm) begin
					if (cv_reg[c] == CNT_ZERO || cv_reg[c][15])
						out_next = act; // [RULE13]
					else if (cv_reg[c] > mod_reg)
						out_next = ~act; // [RULE13]
					else if (match)
						out_next = down_reg ? ~act : act; // [RULE15] [RULE23]
				end else if (pwm_on) begin
					if (match)
						out_next = act; // [RULE8] [RULE9]
					else if (run && cnt_reg == CNT_ZERO)
						out_next = ~act; // [RULE7] [RULE8]
				end else if (mode == M_COMPARE && match) begin
					unique case (els)
						2'b01: out_next = ~ch_out[c]; // [RULE5]
						2'b10: out_next = 1'b0; // [RULE5]
						2'b11: out_next = 1'b1; // [RULE5]
						default: out_next = ch_out[c];
					endcase
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ch_out[c] <= 1'b0;
					ch_oe[c] <= 1'b0;
					in_d_reg[c] <= 1'b0;
				end else begin
					ch_out[c] <= out_next;
					ch_oe[c] <= (cpwm || mode != M_CAPTURE) && els != 2'b00;
					in_d_reg[c] <= ch_in[c];
				end
			end

			// Channel control, event flag and its two-step clear.
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					csc_reg[c] <= '0;
					ch_arm_reg[c] <= 1'b0;
				end else begin
					if (csc_wr)
						csc_reg[c][6:0] <= (pwdata[6:0] & CSC_WMASK[6:0]);
					if (evt) begin
						csc_reg[c][BIT_FLAG] <= 1'b1; // [RULE21]
						ch_arm_reg[c] <= 1'b0;
					end else if (csc_wr && !pwdata[BIT_FLAG] && ch_arm_reg[c]) begin
						csc_reg[c][BIT_FLAG] <= 1'b0; // [RULE21]
						ch_arm_reg[c] <= 1'b0;
					end else if (rd_acc && is_ch(idx, c, 0) && csc_reg[c][BIT_FLAG])
						ch_arm_reg[c] <= 1'b1;
				end
			end

			// Channel value: capture, buffered byte pair, read coherency.
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cv_reg[c] <= '0;
					cv_buf_reg[c] <= '0;
					cv_wr_reg[c] <= '0;
					cv_lat_reg[c] <= '0;
					cv_lat_v_reg[c] <= 1'b0;
				end else if (csc_wr) begin
					cv_wr_reg[c] <= '0; // [RULE6] [RULE17]
					cv_lat_v_reg[c] <= 1'b0; // [RULE3]
				end else begin
					if (wr_acc && is_ch(idx, c, 1)) begin
						cv_buf_reg[c][15:8] <= pwdata[7:0];
						cv_wr_reg[c][1] <= 1'b1;
					end
					if (wr_acc && is_ch(idx, c, 2)) begin
						cv_buf_reg[c][7:0] <= pwdata[7:0];
						cv_wr_reg[c][0] <= 1'b1;
					end
					if (cap)
						cv_reg[c] <= cnt_reg; // [RULE2]
					else if (reload) begin
						cv_reg[c] <= cv_buf_reg[c];
						cv_wr_reg[c] <= '0;
					end
					if (rd_acc && (is_ch(idx, c, 1) || is_ch(idx, c, 2)))
						cv_lat_v_reg[c] <= ~cv_lat_v_reg[c]; // [RULE3]
					// A capture between setup and access must not split the pair.
					if (psel && !penable && !pwrite && !cv_lat_v_reg[c])
						cv_lat_reg[c] <= cv_reg[c]; // [RULE3]
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					channel_irq[c] <= 1'b0;
				else
					channel_irq[c] <= csc_reg[c][BIT_IE] & csc_reg[c][BIT_FLAG]; // [RULE19]
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			overflow_irq <= 1'b0;
		else
			overflow_irq <= tsc_reg[BIT_IE] & tsc_reg[BIT_FLAG]; // [RULE19]
	end
endmodule // timer_channel_capture_compare_pwm
`default_nettype wire

// ===== logic/tmr_pkg.sv
package tmr_pkg;
	localparam int REG_AW = 8;
	localparam int CNT_W = 16;
	localparam logic [7:0] TSC_IDX = 8'h00;
	localparam logic [7:0] CNTH_IDX = 8'h01;
	localparam logic [7:0] CNTL_IDX = 8'h02;
	localparam logic [7:0] MODH_IDX = 8'h03;
	localparam logic [7:0] MODL_IDX = 8'h04;
	localparam logic [7:0] CH_BASE_IDX = 8'h05;
	localparam logic [7:0] CH_STRIDE = 8'h03;
	localparam int BIT_FLAG = 7;
	localparam int BIT_IE = 6;
	localparam int BIT_CPWM = 5;
	localparam int BIT_RUN = 3;
	localparam int BIT_MSB = 5;
	localparam int BIT_MSA = 4;
	localparam int BIT_ELSB = 3;
	localparam int BIT_ELSA = 2;
	localparam logic [7:0] TSC_WMASK = 8'h68;
	localparam logic [7:0] CSC_WMASK = 8'h7C;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ALL1 = 16'hFFFF;
	typedef enum logic [1:0] {
		M_CAPTURE = 2'b00,
		M_COMPARE = 2'b01,
		M_EPWM = 2'b11,
		M_EPWM2 = 2'b10
	} ch_mode_t;
	typedef struct packed {
		logic [REG_AW-1:0] idx;
		logic wr;
		logic [7:0] wdata;
	} bus_req_t;
endpackage

// ===== bench/tmr_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_sva #(
	parameter int NCH = 2
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic [NCH-1:0] ch_in, // Pin inputs
	input wire logic [NCH-1:0] ch_out, // Pin levels
	input wire logic [NCH-1:0] ch_oe, // Pin enables
	input wire logic overflow_irq, // Overflow request
	input wire logic [NCH-1:0] channel_irq // Channel requests
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup; psel && !penable; endsequence
	sequence s_answer; pready ##1 !pready; endsequence
	answer_one_cycle_a: assert property (s_setup |=> s_answer)
		else $error("pready not a single cycle after setup");
	ready_cause_a: assert property ($rose(pready) |-> $past(psel && !penable))
		else $error("pready without a setup cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr outside the access cycle");
	err_zero_a: assert property (pslverr |-> prdata == 32'h0)
		else $error("refused access returned data");
	upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read data bits not zero");
	ovf_clear_a: assert property ($fell(overflow_irq) |-> $past(psel && penable && pwrite, 2))
		else $error("overflow request dropped without a write");
	ch_clear_a: assert property ($fell(channel_irq[0]) |-> $past(psel && penable && pwrite, 2))
		else $error("channel request dropped without a write");
	reset_quiet_a: assert property ($rose(presetn) |-> !pready && ch_out == '0 && channel_irq == '0)
		else $error("outputs active at reset release");
endmodule // tmr_sva
bind timer_channel_capture_compare_pwm tmr_sva #(.NCH(NCH)) chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_in(ch_in), .ch_out(ch_out),
	.ch_oe(ch_oe), .overflow_irq(overflow_irq), .channel_irq(channel_irq));
`default_nettype wire

// ===== bench/pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_model #(
	parameter int NCH = 2
) (
	input wire logic pclk, // Clock
	input wire logic go, // Start two rising edges on pin 0
	input wire logic [NCH-1:0] ch_out, // Device pin level
	input wire logic [NCH-1:0] ch_oe, // Device pin enable
	output logic [NCH-1:0] ch_in // Level on the pins
);
	logic [NCH-1:0] ext = '0;
	// A pin the device drives reads back its own level, otherwise the outside level.
	assign ch_in = (ch_oe & ch_out) | (~ch_oe & ext);
	always @(posedge pclk) begin
		if (go) begin
			ext[0] <= 1'b1;
			repeat (100) @(posedge pclk);
			ext[0] <= 1'b0;
			repeat (100) @(posedge pclk);
			ext[0] <= 1'b1;
		end
	end
endmodule // pin_model
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_count++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb;
	import tmr_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, go, pready, pslverr, overflow_irq, e;
	logic [31:0] paddr, pwdata, prdata;
	logic [1:0] ch_in, ch_out, ch_oe, channel_irq;
	logic [7:0] q, h1, l1, h2, l2;
	int err_count, checks, hi;
	timer_channel_capture_compare_pwm #(.NCH(2)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_in(ch_in), .ch_out(ch_out),
		.ch_oe(ch_oe), .overflow_irq(overflow_irq), .channel_irq(channel_irq));
	pin_model #(.NCH(2)) pm (.pclk(pclk), .go(go), .ch_out(ch_out), .ch_oe(ch_oe), .ch_in(ch_in));
	initial begin
		pclk = 0;
		forever #4 pclk = ~pclk;
	end
	task apb(input logic [7:0] idx, input logic w, input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= {22'h0, idx, 2'b00}; pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (n == 50) err_count++;
		q = prdata[7:0];
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wr(input logic [7:0] idx, input logic [7:0] d); apb(idx, 1'b1, d); endtask
	task rd(input logic [7:0] idx); apb(idx, 1'b0, 8'h00); endtask
	task meas(input int b, input int n);
		hi = 0;
		repeat (n) begin
			@(posedge pclk);
			if (ch_out[b] === 1'b1) hi++;
		end
	endtask
	task t_map;
		rd(TSC_IDX); `CHK("timer control reset", 8'h00, q)
		rd(8'hFF); `CHK("unmapped error", 1'b1, e)
	endtask
	task t_capture;
		wr(8'h05, 8'h44);
		wr(TSC_IDX, 8'h08);
		@(posedge pclk) go <= 1;
		@(posedge pclk) go <= 0;
		repeat (20) @(posedge pclk);
		rd(8'h06); h1 = q;
		repeat (250) @(posedge pclk);
		rd(8'h07); l1 = q;
		rd(8'h06); h2 = q;
		rd(8'h07); l2 = q;
		`CHK("capture spacing", 16'h00C8, ({h2, l2} - {h1, l1}))
		rd(8'h05); `CHK("capture flag", 1'b1, q[BIT_FLAG])
		`CHK("capture irq", 1'b1, channel_irq[0])
	endtask
	task t_compare;
		wr(8'h05, 8'h54);
		repeat (2) @(posedge pclk);
		`CHK("flag cleared", 1'b0, channel_irq[0])
		wr(8'h06, 8'h00); wr(8'h07, 8'h40); wr(CNTH_IDX, 8'h00);
		repeat (100) @(posedge pclk);
		`CHK("compare toggle", 2'b11, {ch_out[0], ch_oe[0]})
		`CHK("compare irq", 1'b1, channel_irq[0])
		wr(8'h06, 8'h12); wr(8'h05, 8'h54); wr(8'h07, 8'h34);
		rd(8'h06); `CHK("value high kept", 8'h00, q)
		rd(8'h07); `CHK("value low kept", 8'h40, q)
		wr(8'h06, 8'h12);
		rd(8'h06); `CHK("value high new", 8'h12, q)
		rd(8'h07); `CHK("value low new", 8'h34, q)
		rd(8'h05); wr(8'h05, 8'h54);
		repeat (2) @(posedge pclk);
		`CHK("compare irq cleared", 1'b0, channel_irq[0])
	endtask
	task t_epwm;
		logic [15:0] v [3];
		int ex [3];
		v = '{16'h0000, 16'h0020, 16'h0004};
		ex = '{0, 160, 40};
		wr(MODH_IDX, 8'h00); wr(MODL_IDX, 8'h0F); wr(8'h08, 8'h28);
		// Restart the counter, else it runs up to FFFF before the new modulo bites.
		wr(CNTH_IDX, 8'h00);
		for (int i = 0; i < 3; i++) begin
			wr(8'h09, v[i][15:8]); wr(8'h0A, v[i][7:0]);
			repeat (40) @(posedge pclk);
			meas(1, 160); `CHK("edge duty", ex[i], hi)
		end
		wr(8'h08, 8'h2C);
		repeat (40) @(posedge pclk);
		meas(1, 160); `CHK("edge duty inverted", 120, hi)
		wr(TSC_IDX, 8'h48);
		repeat (20) @(posedge pclk);
		`CHK("overflow irq", 1'b1, overflow_irq)
	endtask
	task t_cpwm;
		wr(8'h08, 8'h28); wr(MODL_IDX, 8'h07); wr(TSC_IDX, 8'h28);
		repeat (60) @(posedge pclk);
		meas(1, 300); `CHK("center duty", 80, hi)
		wr(8'h09, 8'h80); wr(8'h0A, 8'h04);
		repeat (70) @(posedge pclk);
		meas(1, 300); `CHK("center negative", 0, hi)
		wr(8'h09, 8'h00); wr(8'h0A, 8'h20);
		repeat (70) @(posedge pclk);
		meas(1, 300); `CHK("center full", 300, hi)
		wr(8'h08, 8'h2C);
		repeat (10) @(posedge pclk);
		meas(1, 300); `CHK("center inverted", 0, hi)
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0; go = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		t_map;
		t_capture;
		t_compare;
		t_epwm;
		t_cpwm;
		wrap_up;
	end
	initial begin
		#200000;
		err_count++;
		wrap_up;
	end
endmodule // tb
`default_nettype wire
